//--- verilog/pdma_pkg.sv
// constants, states and helpers shared by the peripheral dma unit
package pdma_pkg;

  // counter field width
  localparam int CNT_W = 16;

  // register offsets on the apb bus
  localparam logic [11:0] OFF_RX_PTR = 12'h100;
  localparam logic [11:0] OFF_RX_CNT = 12'h104;
  localparam logic [11:0] OFF_TX_PTR = 12'h108;
  localparam logic [11:0] OFF_TX_CNT = 12'h10C;
  localparam logic [11:0] OFF_RX_NPTR = 12'h110;
  localparam logic [11:0] OFF_RX_NCNT = 12'h114;
  localparam logic [11:0] OFF_TX_NPTR = 12'h118;
  localparam logic [11:0] OFF_TX_NCNT = 12'h11C;
  localparam logic [11:0] OFF_CTL = 12'h120;
  localparam logic [11:0] OFF_STS = 12'h124;
  localparam logic [11:0] OFF_MODE = 12'h128;
  localparam logic [11:0] OFF_FLAGS = 12'h12C;

  // control, status and flag bit positions
  localparam int CTL_RX_ON = 0;
  localparam int CTL_RX_OFF = 1;
  localparam int CTL_TX_ON = 8;
  localparam int CTL_TX_OFF = 9;
  localparam int STS_RX = 0;
  localparam int STS_TX = 8;
  localparam int FLG_RX_DONE = 0;
  localparam int FLG_TX_DONE = 1;
  localparam int FLG_RX_FULL = 2;
  localparam int FLG_TX_EMPTY = 3;

  // transfer size codes and their address increments
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] MODE_RST = SIZE_BYTE;
  localparam logic [31:0] INC_BYTE = 32'h0000_0001;
  localparam logic [31:0] INC_HALF = 32'h0000_0002;
  localparam logic [31:0] INC_WORD = 32'h0000_0004;

  // transfer sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_RX_MEM, ST_TX_MEM, ST_SETTLE} st_t;

  // address step for one transfer of the given size
  function automatic logic [31:0] step_of(input logic [1:0] sz);
    case (sz)
      SIZE_BYTE: step_of = INC_BYTE;
      SIZE_HALF: step_of = INC_HALF;
      default: step_of = INC_WORD;
    endcase
  endfunction

endpackage

//--- verilog/pdma_ifs.sv
// interfaces between the unit, its channels and its memory port
`timescale 1ns/1ps
`default_nettype none

// one channel: register writes in, pointer and counter state out
interface chan_if;
  logic wr_ptr, wr_cnt, wr_nptr, wr_ncnt;
  logic [31:0] wdata;
  logic step;
  logic [31:0] inc;
  logic [31:0] ptr, nptr;
  logic [pdma_pkg::CNT_W-1:0] cnt, ncnt;
  logic end_flag, all_flag;
  modport ctl(output wr_ptr, wr_cnt, wr_nptr, wr_ncnt, wdata, step, inc,
              input ptr, nptr, cnt, ncnt, end_flag, all_flag);
  modport chan(input wr_ptr, wr_cnt, wr_nptr, wr_ncnt, wdata, step, inc,
               output ptr, nptr, cnt, ncnt, end_flag, all_flag);
endinterface

// memory request from the sequencer to the memory port
interface mem_if;
  logic start, we;
  logic [31:0] addr, wdata, rdata;
  logic [1:0] size;
  logic done;
  modport ctl(output start, we, addr, wdata, size, input done, rdata);
  modport port(input start, we, addr, wdata, size, output done, rdata);
endinterface

`default_nettype wire

//--- verilog/dma_channel.sv
// pointer, counter and chaining logic of one transfer direction
`timescale 1ns/1ps
`default_nettype none

module dma_channel (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // channel link to the unit
  chan_if.chan c
);

  logic any_cnt_wr;
  logic load;

  assign any_cnt_wr = c.wr_cnt | c.wr_ncnt;
  // RULE16: chain reload
  assign load = (c.cnt == '0) && (c.ncnt != '0) && !any_cnt_wr;

  // active pointer
  always_ff @(posedge sys_clk) begin
    if (srst) c.ptr <= 32'h0000_0000;
    else if (c.wr_ptr) c.ptr <= c.wdata;
    else if (load) c.ptr <= c.nptr;
    else if (c.step) c.ptr <= c.ptr + c.inc;
  end

  // active counter
  always_ff @(posedge sys_clk) begin
    if (srst) c.cnt <= '0;
    else if (c.wr_cnt) c.cnt <= c.wdata[pdma_pkg::CNT_W-1:0];
    else if (load) c.cnt <= c.ncnt;
    else if (c.step && c.cnt != '0) c.cnt <= c.cnt - 1'b1;
  end

  // chained pointer and counter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      c.nptr <= 32'h0000_0000;
      c.ncnt <= '0;
    end else begin
      if (c.wr_nptr) c.nptr <= c.wdata;
      if (c.wr_ncnt) c.ncnt <= c.wdata[pdma_pkg::CNT_W-1:0];
      else if (load) c.ncnt <= '0;
    end
  end

  // end flags
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      c.end_flag <= 1'b0;
      c.all_flag <= 1'b0;
    end else begin
      // RULE18: counter write clears
      if (any_cnt_wr) c.end_flag <= 1'b0;
      else if (c.cnt == '0) c.end_flag <= 1'b1;
      // RULE17: both counters empty
      c.all_flag <= (c.cnt == '0) && (c.ncnt == '0);
    end
  end

  property p_load;
    @(posedge sys_clk) disable iff (srst)
      load |=> (c.cnt == $past(c.ncnt)) && (c.ncnt == '0 || $past(c.wr_ncnt));
  endproperty
  a_load: assert property (p_load) else $error("chained buffer not loaded"); // RULE16

  property p_step;
    @(posedge sys_clk) disable iff (srst)
      (c.step && c.cnt != '0 && !c.wr_ptr && !any_cnt_wr)
      |=> (c.ptr == $past(c.ptr) + $past(c.inc)) && (c.cnt == $past(c.cnt) - 1'b1);
  endproperty
  a_step: assert property (p_step) else $error("pointer or counter not stepped"); // RULE15

  property p_clear;
    @(posedge sys_clk) disable iff (srst)
      any_cnt_wr |=> !c.end_flag ##1 (c.end_flag == ($past(c.cnt) == '0));
  endproperty
  a_clear: assert property (p_clear) else $error("end flag not cleared by write"); // RULE18

  property p_full;
    @(posedge sys_clk) disable iff (srst)
      (c.cnt == '0 && c.ncnt == '0) |=> c.all_flag;
  endproperty
  a_full: assert property (p_full) else $error("all-buffers flag missing"); // RULE17

endmodule

`default_nettype wire

//--- verilog/mem_port.sv
// holds one memory request until the bus acknowledges it
`timescale 1ns/1ps
`default_nettype none

module mem_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // request from the sequencer
  mem_if.port m,
  // system memory bus
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);

  // request hold until acknowledge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_size <= 2'h0;
      mem_wdata <= 32'h0000_0000;
    end else if (m.start && !mem_req) begin
      mem_req <= 1'b1;
      mem_we <= m.we;
      mem_addr <= m.addr;
      mem_size <= m.size;
      mem_wdata <= m.wdata;
    end else if (mem_req && mem_ack) begin
      mem_req <= 1'b0;
    end
  end

  // completion pulse and read data capture
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      m.done <= 1'b0;
      m.rdata <= 32'h0000_0000;
    end else begin
      m.done <= mem_req && mem_ack;
      if (mem_req && mem_ack && !mem_we) m.rdata <= mem_rdata;
    end
  end

endmodule

`default_nettype wire

//--- verilog/pdma_unit.sv
// apb register file and transfer sequencer of a paired peripheral dma channel
//
// What this block does
// RULE1: receive pointer, 32-bit read-write memory address
// RULE2: receive counter, 16-bit read-write remaining transfers
// RULE3: transmit pointer, 32-bit read-write fetch address
// RULE4: transmit counter; no transmit transfer at zero
// RULE5: receive chain pointer, next buffer address
// RULE6: receive chain size, next buffer count
// RULE7: transmit chain pointer, next buffer address
// RULE8: transmit chain size, next buffer count
// RULE9: receive on-bit enables unless off-bit set
// RULE10: receive off-bit disables receive requests
// RULE11: transmit on-bit 8 enables transmit requests
// RULE12: transmit off-bit 9 disables transmit requests
// RULE13: status bit 0 shows receive enable
// RULE14: status bit 8 shows transmit enable
// RULE15: step pointer by size, decrement counter
// RULE16: at zero load chain pair, clear chain size
// RULE17: done flag at zero, all-flag when both zero
// RULE18: counter writes clear the done flag
// RULE19: transmit off wins over transmit on
// RULE20: both directions disabled after reset
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module pdma_unit (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // serial peripheral receive side
  input wire logic rx_holding_full,
  input wire logic [31:0] rx_data,
  output logic rx_take,
  // serial peripheral transmit side
  input wire logic tx_holding_free,
  output logic [31:0] tx_data,
  output logic tx_load,
  // end flags to the peripheral
  output logic rx_buffer_done,
  output logic tx_buffer_done,
  output logic rx_all_buffers_full,
  output logic tx_all_buffers_empty,
  // system memory bus
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);

  chan_if rx ();
  chan_if tx ();
  mem_if m ();

  pdma_pkg::st_t state_r;
  logic rx_on_r;
  logic tx_on_r;
  logic [1:0] size_r;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [31:0] wmerged;
  logic [31:0] wbits;
  logic wr_acc;
  logic rd_prep;
  logic ctl_wr;
  logic go_rx;
  logic go_tx;

  // word-address match of the bus address against an offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  // byte-lane merge of write data into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
    end
    merge = res;
  endfunction

  // channel and memory port instances
  dma_channel u_rx (
    .sys_clk(sys_clk),
    .srst(srst),
    .c(rx.chan)
  );

  dma_channel u_tx (
    .sys_clk(sys_clk),
    .srst(srst),
    .c(tx.chan)
  );

  mem_port u_mem (
    .sys_clk(sys_clk),
    .srst(srst),
    .m(m.port),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_size(mem_size),
    .mem_wdata(mem_wdata),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  // apb phase qualifiers
  assign rd_prep = psel & penable & ~pready;
  assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
  assign ctl_wr = wr_acc & hit(paddr, pdma_pkg::OFF_CTL);
  assign wmerged = merge(rd_val, pwdata, pstrb);
  assign wbits = merge(32'h0000_0000, pwdata, pstrb);

  // read mux, also the base for byte-lane merging
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (1'b1)
      // RULE1: receive pointer readback
      hit(paddr, pdma_pkg::OFF_RX_PTR): rd_val = rx.ptr;
      // RULE2: receive counter readback
      hit(paddr, pdma_pkg::OFF_RX_CNT): rd_val = {16'h0000, rx.cnt};
      // RULE3: transmit pointer readback
      hit(paddr, pdma_pkg::OFF_TX_PTR): rd_val = tx.ptr;
      // RULE4: transmit counter readback
      hit(paddr, pdma_pkg::OFF_TX_CNT): rd_val = {16'h0000, tx.cnt};
      // RULE5: receive chain pointer
      hit(paddr, pdma_pkg::OFF_RX_NPTR): rd_val = rx.nptr;
      // RULE6: receive chain size
      hit(paddr, pdma_pkg::OFF_RX_NCNT): rd_val = {16'h0000, rx.ncnt};
      // RULE7: transmit chain pointer
      hit(paddr, pdma_pkg::OFF_TX_NPTR): rd_val = tx.nptr;
      // RULE8: transmit chain size
      hit(paddr, pdma_pkg::OFF_TX_NCNT): rd_val = {16'h0000, tx.ncnt};
      hit(paddr, pdma_pkg::OFF_CTL): rd_val = 32'h0000_0000; // write-only
      hit(paddr, pdma_pkg::OFF_STS): begin
        // RULE13: receive enable status
        rd_val[pdma_pkg::STS_RX] = rx_on_r;
        // RULE14: transmit enable status
        rd_val[pdma_pkg::STS_TX] = tx_on_r;
      end
      hit(paddr, pdma_pkg::OFF_MODE): rd_val = {30'h0000_0000, size_r};
      hit(paddr, pdma_pkg::OFF_FLAGS): begin
        rd_val[pdma_pkg::FLG_RX_DONE] = rx.end_flag;
        rd_val[pdma_pkg::FLG_TX_DONE] = tx.end_flag;
        rd_val[pdma_pkg::FLG_RX_FULL] = rx.all_flag;
        rd_val[pdma_pkg::FLG_TX_EMPTY] = tx.all_flag;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // apb answer: one wait cycle, then ready with data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_prep) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= ~rd_hit;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // register writes into the receive channel
  assign rx.wdata = wmerged;
  assign rx.wr_ptr = wr_acc & hit(paddr, pdma_pkg::OFF_RX_PTR);
  assign rx.wr_cnt = wr_acc & hit(paddr, pdma_pkg::OFF_RX_CNT);
  assign rx.wr_nptr = wr_acc & hit(paddr, pdma_pkg::OFF_RX_NPTR);
  assign rx.wr_ncnt = wr_acc & hit(paddr, pdma_pkg::OFF_RX_NCNT);

  // register writes into the transmit channel
  assign tx.wdata = wmerged;
  assign tx.wr_ptr = wr_acc & hit(paddr, pdma_pkg::OFF_TX_PTR);
  assign tx.wr_cnt = wr_acc & hit(paddr, pdma_pkg::OFF_TX_CNT);
  assign tx.wr_nptr = wr_acc & hit(paddr, pdma_pkg::OFF_TX_NPTR);
  assign tx.wr_ncnt = wr_acc & hit(paddr, pdma_pkg::OFF_TX_NCNT);

  // receive request enable
  always_ff @(posedge sys_clk) begin
    // RULE20: disabled out of reset
    if (srst) rx_on_r <= 1'b0;
    // RULE10: off-bit disables
    else if (ctl_wr && wbits[pdma_pkg::CTL_RX_OFF]) rx_on_r <= 1'b0;
    // RULE9: on-bit enables
    else if (ctl_wr && wbits[pdma_pkg::CTL_RX_ON]) rx_on_r <= 1'b1;
  end

  // transmit request enable
  always_ff @(posedge sys_clk) begin
    if (srst) tx_on_r <= 1'b0;
    // RULE12: off-bit disables
    // RULE19: off wins over on
    else if (ctl_wr && wbits[pdma_pkg::CTL_TX_OFF]) tx_on_r <= 1'b0;
    // RULE11: on-bit enables
    else if (ctl_wr && wbits[pdma_pkg::CTL_TX_ON]) tx_on_r <= 1'b1;
  end

  // transfer size selection
  always_ff @(posedge sys_clk) begin
    if (srst) size_r <= pdma_pkg::MODE_RST;
    else if (wr_acc && hit(paddr, pdma_pkg::OFF_MODE)) size_r <= wmerged[1:0];
  end

  // request arbitration, receive first
  assign go_rx = rx_on_r & rx_holding_full & (rx.cnt != '0);
  // RULE4: no transmit fetch at zero count
  assign go_tx = tx_on_r & tx_holding_free & (tx.cnt != '0) & ~go_rx;

  // memory request launch
  assign m.start = (state_r == pdma_pkg::ST_IDLE) && (go_rx || go_tx);
  assign m.we = go_rx;
  assign m.addr = go_rx ? rx.ptr : tx.ptr;
  assign m.wdata = rx_data;
  assign m.size = size_r;

  // RULE15: step after each completed transfer
  assign rx.step = (state_r == pdma_pkg::ST_RX_MEM) && m.done;
  assign tx.step = (state_r == pdma_pkg::ST_TX_MEM) && m.done;
  assign rx.inc = pdma_pkg::step_of(size_r);
  assign tx.inc = pdma_pkg::step_of(size_r);

  // transfer sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) state_r <= pdma_pkg::ST_IDLE;
    else begin
      case (state_r)
        pdma_pkg::ST_IDLE: begin
          if (go_rx) state_r <= pdma_pkg::ST_RX_MEM;
          else if (go_tx) state_r <= pdma_pkg::ST_TX_MEM;
        end
        pdma_pkg::ST_RX_MEM: begin
          if (m.done) state_r <= pdma_pkg::ST_IDLE;
        end
        pdma_pkg::ST_TX_MEM: begin
          if (m.done) state_r <= pdma_pkg::ST_SETTLE;
        end
        // lets the peripheral drop its free strobe
        pdma_pkg::ST_SETTLE: state_r <= pdma_pkg::ST_IDLE;
        default: state_r <= pdma_pkg::ST_IDLE;
      endcase
    end
  end

  // peripheral strobes and transmit data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_take <= 1'b0;
      tx_load <= 1'b0;
      tx_data <= 32'h0000_0000;
    end else begin
      rx_take <= (state_r == pdma_pkg::ST_IDLE) && go_rx;
      tx_load <= tx.step;
      if (tx.step) tx_data <= m.rdata;
    end
  end

  // RULE17: end flags to the peripheral
  assign rx_buffer_done = rx.end_flag;
  assign tx_buffer_done = tx.end_flag;
  assign rx_all_buffers_full = rx.all_flag;
  assign tx_all_buffers_empty = tx.all_flag;

  property p_rx_on;
    @(posedge sys_clk) disable iff (srst)
      (ctl_wr && wbits[pdma_pkg::CTL_RX_ON] && !wbits[pdma_pkg::CTL_RX_OFF]) |=> rx_on_r;
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("receive enable not set"); // RULE9

  property p_rx_off;
    @(posedge sys_clk) disable iff (srst)
      (ctl_wr && wbits[pdma_pkg::CTL_RX_OFF]) |=> !rx_on_r;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receive disable ignored"); // RULE10

  property p_tx_off_wins;
    @(posedge sys_clk) disable iff (srst)
      (ctl_wr && wbits[pdma_pkg::CTL_TX_ON] && wbits[pdma_pkg::CTL_TX_OFF]) |=> !tx_on_r;
  endproperty
  a_tx_off_wins: assert property (p_tx_off_wins) else $error("transmit off lost"); // RULE19

  property p_reset_off;
    @(posedge sys_clk) disable iff (srst)
      $fell(srst) |-> (!rx_on_r && !tx_on_r);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("enabled after reset"); // RULE20

  property p_tx_stop;
    @(posedge sys_clk) disable iff (srst)
      (state_r == pdma_pkg::ST_IDLE && tx.cnt == '0) |=> state_r != pdma_pkg::ST_TX_MEM;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("transmit with zero count"); // RULE4

  property p_status;
    @(posedge sys_clk) disable iff (srst)
      (rd_prep && !pwrite && hit(paddr, pdma_pkg::OFF_STS))
      |=> pready && prdata[pdma_pkg::STS_RX] == $past(rx_on_r)
          && prdata[pdma_pkg::STS_TX] == $past(tx_on_r);
  endproperty
  a_status: assert property (p_status) else $error("status readback wrong"); // RULE13

endmodule

`default_nettype wire

//--- bench/pdma_partner.sv
// partner model: serial peripheral strobes and a memory with a set wait
`timescale 1ns/1ps
`default_nettype none
module pdma_partner (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // bench controls
  input wire logic rx_push,
  input wire logic [31:0] rx_item,
  input wire logic [2:0] ack_wait,
  // peripheral strobes
  output logic rx_holding_full,
  output logic [31:0] rx_data,
  input wire logic rx_take,
  output logic tx_holding_free,
  input wire logic tx_load,
  // memory bus
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] item_r, cyc_r;
  logic [2:0] wait_r;
  logic [1:0] gap_r;
  // released lines show the inverse or a moving pattern
  assign rx_data = rx_holding_full ? item_r : ~item_r;
  assign mem_rdata = mem_ack ? ~mem_addr : cyc_r;
  // receive holding register, emptied by a take
  always_ff @(posedge sys_clk) begin
    if (srst || rx_take) begin
      rx_holding_full <= 1'b0;
    end else if (rx_push) begin
      rx_holding_full <= 1'b1;
      item_r <= rx_item;
    end
  end
  // transmit holding register, free again three cycles after a load
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_holding_free <= 1'b1;
      gap_r <= 2'h0;
    end else if (tx_load) begin
      tx_holding_free <= 1'b0;
      gap_r <= 2'h3;
    end else if (gap_r == 2'h1) begin
      tx_holding_free <= 1'b1;
      gap_r <= 2'h0;
    end else if (gap_r != 2'h0) begin
      gap_r <= gap_r - 2'h1;
    end
  end
  // memory acknowledges after ack_wait cycles, for one cycle
  always_ff @(posedge sys_clk) begin
    cyc_r <= srst ? 32'h0000_0000 : cyc_r + 32'h0000_0001;
    if (srst || !mem_req || mem_ack) begin
      wait_r <= 3'h0;
      mem_ack <= 1'b0;
    end else if (wait_r >= ack_wait) begin
      mem_ack <= 1'b1;
    end else begin
      wait_r <= wait_r + 3'h1;
    end
  end
endmodule
`default_nettype wire

//--- bench/peripheral_dma_channel_regs_tb.sv
// self-checking bench of the peripheral dma unit
`timescale 1ns/1ps
`default_nettype none
module peripheral_dma_channel_regs_tb;
  logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, rx_push, mem_ack;
  logic rx_holding_full, rx_take, tx_holding_free, tx_load, mem_req, mem_we;
  logic rx_buffer_done, tx_buffer_done, rx_all_buffers_full, tx_all_buffers_empty;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rx_data, tx_data, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] rx_item, seed, p, q, v;
  logic [1:0] mem_size;
  logic [2:0] ack_wait;
  logic [1:0] sz_e;
  logic [63:0] exp_rd[$], exp_wr[$], exp_ta[$], exp_td[$];
  logic [31:0] ctl_v[7] = '{32'h0000_0003, 32'h0000_0300, 32'h0000_0001, 32'h0000_0100,
    32'h0000_0000, 32'h0000_0200, 32'h0000_0002};
  logic [31:0] sts_v[7] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 32'h0000_0101,
    32'h0000_0101, 32'h0000_0001, 32'h0000_0000};
  int n_fail, checks_done;

  pdma_unit dut (.sys_clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF),
    .pready, .prdata, .pslverr, .rx_holding_full, .rx_data, .rx_take, .tx_holding_free,
    .tx_data, .tx_load, .rx_buffer_done, .tx_buffer_done, .rx_all_buffers_full,
    .tx_all_buffers_empty, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_wdata, .mem_ack,
    .mem_rdata);
  pdma_partner partner (.sys_clk, .srst, .rx_push, .rx_item, .ack_wait, .rx_holding_full,
    .rx_data, .rx_take, .tx_holding_free, .tx_load, .mem_req, .mem_addr, .mem_ack, .mem_rdata);

  // clock generator
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task give_verdict();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // apb master: setup, access, hold until pready sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_rd.push_back({31'h0, err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // peripheral item, noted with the memory address it must reach
  task automatic push(input logic [31:0] a);
    @(posedge sys_clk);
    while (rx_holding_full !== 1'b0) begin
      @(posedge sys_clk);
    end
    v = rnd();
    exp_wr.push_back({a, v});
    ack_wait <= v[31:29];
    rx_item <= v;
    rx_push <= 1'b1;
    @(posedge sys_clk);
    rx_push <= 1'b0;
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (exp_wr.size() + exp_ta.size() + exp_td.size() != 0 && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (4) @(posedge sys_clk);
    chk("pending results", 64'h0, 64'(exp_wr.size() + exp_ta.size() + exp_td.size()));
  endtask

  // result watcher: each result but the memory size is compared with the oldest note
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0)
      chk("apb read", exp_rd.size() != 0 ? exp_rd.pop_front() : 'x,
        {31'h0, pslverr, prdata});
    if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b1)
      chk("mem write", exp_wr.size() != 0 ? exp_wr.pop_front() : 'x,
        {mem_addr, mem_wdata});
    if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b0)
      chk("mem read", exp_ta.size() != 0 ? exp_ta.pop_front() : 'x,
        {32'h0, mem_addr});
    if (mem_req === 1'b1 && mem_ack === 1'b1)
      chk("mem size", 64'(sz_e), 64'(mem_size));
    if (tx_load === 1'b1)
      chk("tx data", exp_td.size() != 0 ? exp_td.pop_front() : 'x,
        {32'h0, tx_data});
  end

  // watchdog
  initial begin
    #(20 * 30000);
    n_fail++;
    give_verdict();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, rx_push} = 4'h0;
    {paddr, pwdata, rx_item} = '0;
    ack_wait = 3'h0;
    sz_e = 2'h0;
    seed = 32'h0000_45CC;
    srst = 1'b1;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 10; i++) rd(pdma_pkg::OFF_RX_PTR + 12'(4 * i), 0);
    rd(12'h130, 32'h0000_0000, 1'b1);
    rd(pdma_pkg::OFF_FLAGS, 32'h0000_000F);
    rd(pdma_pkg::OFF_MODE, 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, pdma_pkg::OFF_CTL, ctl_v[i]);
      rd(pdma_pkg::OFF_STS, sts_v[i]);
    end
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      apb(1'b1, pdma_pkg::OFF_RX_PTR + 12'(4 * i), v);
      rd(pdma_pkg::OFF_RX_PTR + 12'(4 * i), i[0] ? v & 32'h0000_FFFF : v);
    end
    for (int sz = 0; sz < 4; sz++) begin
      p = rnd();
      q = rnd();
      sz_e = 2'(sz);
      apb(1'b1, pdma_pkg::OFF_MODE, 32'(sz));
      apb(1'b1, pdma_pkg::OFF_RX_PTR, p);
      apb(1'b1, pdma_pkg::OFF_RX_CNT, 32'h0000_0001);
      apb(1'b1, pdma_pkg::OFF_RX_NPTR, q);
      apb(1'b1, pdma_pkg::OFF_RX_NCNT, 32'h0000_0001);
      apb(1'b1, pdma_pkg::OFF_CTL, 32'h0000_0001);
      push(p);
      push(q);
      drain();
      rd(pdma_pkg::OFF_RX_PTR, q + (32'h0000_0001 << (sz == 3 ? 2 : sz)));
      rd(pdma_pkg::OFF_RX_NCNT, 32'h0000_0000);
      chk("rx flags", 2'b11, {rx_buffer_done, rx_all_buffers_full});
    end
    v = rnd();
    rx_item <= v;
    rx_push <= 1'b1;
    @(posedge sys_clk);
    rx_push <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk("rx item held", 1'b1, rx_holding_full);
    exp_wr.push_back({q + 32'h0000_0004, v});
    apb(1'b1, pdma_pkg::OFF_RX_CNT, 32'h0000_0001);
    @(posedge sys_clk);
    #1 chk("rx end flag", 1'b0, rx_buffer_done);
    drain();
    p = rnd();
    ack_wait <= 3'h0;
    apb(1'b1, pdma_pkg::OFF_TX_PTR, p);
    apb(1'b1, pdma_pkg::OFF_TX_CNT, 32'h0000_0001);
    apb(1'b1, pdma_pkg::OFF_TX_NPTR, p + 32'h0000_0004);
    apb(1'b1, pdma_pkg::OFF_TX_NCNT, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      exp_ta.push_back({32'h0, p + 32'(4 * i)});
      exp_td.push_back({32'h0, ~(p + 32'(4 * i))});
    end
    apb(1'b1, pdma_pkg::OFF_CTL, 32'h0000_0100);
    drain();
    rd(pdma_pkg::OFF_TX_PTR, p + 32'h0000_0008);
    chk("tx flags", 2'b11, {tx_buffer_done, tx_all_buffers_empty});
    apb(1'b1, pdma_pkg::OFF_CTL, 32'h0000_0202);
    rd(pdma_pkg::OFF_STS, 32'h0000_0000);
    // mid-run reset with both directions enabled
    apb(1'b1, pdma_pkg::OFF_CTL, 32'h0000_0101);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rd(pdma_pkg::OFF_STS, 32'h0000_0000);
    rd(pdma_pkg::OFF_RX_PTR, 32'h0000_0000);
    give_verdict();
  end
endmodule
`default_nettype wire
